/* File: verilog/dba_bank_addr.sv */
// Bank select, row/column multiplexing and strobe generation
`timescale 1ns/10ps
module dba_bank_addr #(
  parameter int NUM_BANKS = dba_pkg::NUM_BANKS,
  parameter int MA_W      = dba_pkg::MA_W
) (
  input  wire logic                      clk_sys_in,
  input  wire logic                      resetn_in,
  input  wire logic                      clk_en_in,
  // Access request
  input  wire logic                      req_valid_in,
  input  wire dba_pkg::dba_req_t         req_in,
  input  wire logic                      req_write_in,
  output logic                           req_ready_out,
  output logic                           req_done_out,
  output logic                           req_miss_out,
  // Bank map and mode, held by the configuration block
  input  wire logic [NUM_BANKS-1:0]      bank_en_in,
  input  wire dba_pkg::dba_bank_cfg_t [NUM_BANKS-1:0] bank_cfg_in,
  input  wire logic                      ecc_en_in,
  input  wire logic                      rmw_par_en_in,
  // Data path between core and memory
  input  wire logic [dba_pkg::DATA_W-1:0] wdata_in,
  input  wire logic [dba_pkg::CHK_W-1:0]  wchk_in,
  output logic      [dba_pkg::DATA_W-1:0] rdata_out,
  output logic      [dba_pkg::CHK_W-1:0]  rchk_out,
  // Memory pins
  output logic      [MA_W-1:0]           muxed_dram_addr_out,
  output logic      [NUM_BANKS-1:0]      ras_n_out,
  output logic      [dba_pkg::LANES-1:0] cas_n_out,
  output logic                           we_n_out,
  input  wire logic [31:0]               data_upper_half_in,
  input  wire logic [31:0]               data_lower_half_in,
  output logic      [31:0]               data_upper_half_out,
  output logic      [31:0]               data_lower_half_out,
  output logic                           data_oe_n_out,
  input  wire logic [dba_pkg::CHK_W-1:0] check_bit_lines_in,
  output logic      [dba_pkg::CHK_W-1:0] check_bit_lines_out,
  output logic                           check_oe_n_out
);
  // Big-endian address bit n sits at index 31-n
  function automatic logic pa(input logic [31:0] a, input int n);
    pa = a[31-n];
  endfunction

  dba_pkg::dba_state_t state_reg, state_next;
  dba_pkg::dba_req_t   req_reg;
  logic                write_reg;
  logic [1:0]          cnt_reg;
  logic [NUM_BANKS-1:0] hit_reg;
  logic [MA_W-1:0]     ma_reg, ma_next;
  logic [NUM_BANKS-1:0] ras_n_reg, ras_n_next;
  logic [7:0]          cas_n_reg, cas_n_next;
  logic                we_n_reg;
  logic [31:0]         dh_reg, dl_reg;
  logic [7:0]          chk_reg;
  logic                oe_n_reg;
  logic [63:0]         rdata_reg;
  logic [7:0]          rchk_reg;

  // Bank hit: compare A[0:9] (4 Mbyte granule) against each window
  logic [dba_pkg::BOUND_W-1:0] addr_mb;
  logic [NUM_BANKS-1:0]         hit_vec;
  logic [NUM_BANKS-1:0]         hit_one;
  assign addr_mb = req_in.addr[31 -: dba_pkg::BOUND_W];

  genvar gb;
  generate
    for (gb = 0; gb < NUM_BANKS; gb++) begin : g_hit
      // Each bank keeps its own window; banks may differ
      assign hit_vec[gb] = bank_en_in[gb] && !req_in.rom &&
                           addr_mb >= bank_cfg_in[gb].start_mb &&
                           addr_mb <= bank_cfg_in[gb].end_mb;
    end
  endgenerate
  // Overlapping windows: lowest bank wins, so one strobe only
  assign hit_one = hit_vec & (~hit_vec + NUM_BANKS'(1));

  // Selected bank row setting from the registered hit
  logic [1:0] row_code;
  logic       thirteen;
  always_comb begin
    row_code = dba_pkg::ROW_RST;
    thirteen = 1'b0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (hit_reg[i]) begin
        row_code = bank_cfg_in[i].row_code;
        thirteen = bank_cfg_in[i].col13_11;
      end
    end
  end

  // Row and column address images per setting
  logic [MA_W-1:0] row_addr, col_addr, rom_addr;
  logic [31:0]     a;
  logic [7:0]      col_lo;
  assign a = req_reg.addr;
  // Pins 5..12 take A21..A28 in the column phase of every DRAM access
  assign col_lo = {pa(a,21),pa(a,22),pa(a,23),pa(a,24),
                   pa(a,25),pa(a,26),pa(a,27),pa(a,28)};
  // ma[12-k] is pin k; pin 12 is the device A0 lsb
  always_comb begin
    row_addr = '0;
    col_addr = {5'h00, col_lo};
    for (int k = 4; k <= 12; k++) row_addr[12-k] = pa(a, k + 8);
    unique case (row_code)
      dba_pkg::ROW_9: begin
        col_addr[8] = pa(a,11);
      end
      dba_pkg::ROW_10: begin
        row_addr[9]  = pa(a,11);
        col_addr[9]  = pa(a,9);
        col_addr[8]  = pa(a,10);
      end
      dba_pkg::ROW_11: begin
        row_addr[10] = pa(a,10);
        row_addr[9]  = pa(a,11);
        col_addr[10] = pa(a,7);
        col_addr[9]  = pa(a,8);
        col_addr[8]  = pa(a,9);
      end
      dba_pkg::ROW_12: begin
        row_addr[11] = pa(a,9);
        row_addr[10] = pa(a,10);
        row_addr[9]  = pa(a,11);
        col_addr[11] = pa(a,5);
        col_addr[10] = pa(a,6);
        col_addr[9]  = pa(a,7);
        col_addr[8]  = pa(a,8);
        if (thirteen) begin
          row_addr[12] = pa(a,5);   // Pin 0 is the 13th row bit
          col_addr[11] = 1'b0;      // Only eleven column bits
        end
      end
    endcase
  end

  // Boot ROM: pins 4..12 carry ROM bits 12..20, bit 20 lsb
  always_comb begin
    rom_addr = '0;
    for (int k = 4; k <= 12; k++) rom_addr[12-k] = pa(a, k + 8);
  end

  // Lane decode; check modes force a full double word
  logic [7:0] lanes;
  dba_lane_dec u_lane (
    .addr_low_in (req_reg.addr[2:0]),
    .tsize_in    (req_reg.tsize),
    .burst_in    (req_reg.burst),
    .full_dw_in  (ecc_en_in || rmw_par_en_in),
    .lanes_out   (lanes)
  );

  wire cnt_done = (cnt_reg == 2'h0);
  assign req_ready_out = (state_reg == dba_pkg::DBA_IDLE);

  // Sequencer: row phase then column phase
  always_comb begin
    state_next = state_reg;
    ma_next    = ma_reg;
    ras_n_next = ras_n_reg;
    cas_n_next = cas_n_reg;
    unique case (state_reg)
      dba_pkg::DBA_IDLE: begin
        ras_n_next = '1;
        cas_n_next = '1;
      end
      dba_pkg::DBA_ROW: begin
        ma_next    = req_reg.rom ? rom_addr : row_addr;
        ras_n_next = ~hit_reg;
        if (cnt_done) state_next = dba_pkg::DBA_COL;
      end
      dba_pkg::DBA_COL: begin
        ma_next    = req_reg.rom ? rom_addr : col_addr;
        cas_n_next = (|hit_reg) ? ~lanes : 8'hff;
        if (cnt_done) state_next = dba_pkg::DBA_IDLE;
      end
      default: state_next = dba_pkg::DBA_IDLE;
    endcase
  end

  // State, phase counter and request capture
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= dba_pkg::DBA_IDLE;
      cnt_reg   <= 2'h0;
      req_reg   <= '0;
      write_reg <= 1'b0;
      hit_reg   <= '0;
    end else if (clk_en_in) begin
      state_reg <= state_next;
      if (req_valid_in && req_ready_out) begin
        req_reg   <= req_in;
        write_reg <= req_write_in;
        hit_reg   <= hit_one;
        cnt_reg   <= dba_pkg::ROW_CYC - 2'h1;
      end else if (state_reg == dba_pkg::DBA_ROW && cnt_done) begin
        cnt_reg <= dba_pkg::COL_CYC - 2'h1;
      end else if (!cnt_done) begin
        cnt_reg <= cnt_reg - 2'h1;
      end
      if (req_valid_in && req_ready_out) state_reg <= dba_pkg::DBA_ROW;
    end
  end

  // Pin registers
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ma_reg    <= '0;
      ras_n_reg <= '1;
      cas_n_reg <= '1;
    end else if (clk_en_in) begin
      ma_reg    <= ma_next;
      ras_n_reg <= ras_n_next;
      cas_n_reg <= cas_n_next;
    end
  end

  // Write data and check bits; ROM cycles leave check lines undriven
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      dh_reg   <= '0;
      dl_reg   <= '0;
      chk_reg  <= '0;
    end else if (clk_en_in) begin
      we_n_reg <= !(write_reg && state_next == dba_pkg::DBA_COL &&
                    |hit_reg);
      oe_n_reg <= !(write_reg && state_next != dba_pkg::DBA_IDLE &&
                    |hit_reg);
      dh_reg   <= wdata_in[63:32];
      dl_reg   <= wdata_in[31:0];
      chk_reg  <= wchk_in;
    end
  end

  // Read capture at the end of the column phase
  wire col_end = (state_reg == dba_pkg::DBA_COL) && cnt_done;
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_reg <= '0;
      rchk_reg  <= '0;
    end else if (clk_en_in && col_end && !write_reg) begin
      rdata_reg <= {data_upper_half_in, data_lower_half_in};
      rchk_reg  <= check_bit_lines_in;
    end
  end

  assign req_done_out        = clk_en_in && col_end;
  assign req_miss_out        = clk_en_in && col_end && !(|hit_reg);
  assign muxed_dram_addr_out = ma_reg;
  assign ras_n_out           = ras_n_reg;
  assign cas_n_out           = cas_n_reg;
  assign we_n_out            = we_n_reg;
  assign data_upper_half_out = dh_reg;
  assign data_lower_half_out = dl_reg;
  assign data_oe_n_out       = oe_n_reg;
  assign check_bit_lines_out = chk_reg;
  assign check_oe_n_out      = oe_n_reg;
  assign rdata_out           = rdata_reg;
  assign rchk_out            = rchk_reg;

  // Checks
  a_ras_onehot: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    $countones(~ras_n_out) <= 1)
    else $error("more than one row strobe");
  a_ras_miss: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (state_reg != dba_pkg::DBA_IDLE && hit_reg == '0) |-> ras_n_next == '1)
    else $error("row strobe on a miss");
  a_ecc_allcas: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (clk_en_in && state_reg == dba_pkg::DBA_COL && |hit_reg && ecc_en_in)
    |=> cas_n_out == 8'h00)
    else $error("ecc access without all lanes");
  a_rmw_fulldw: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (rmw_par_en_in || ecc_en_in) |-> lanes == 8'hff)
    else $error("partial lanes in check mode");
  a_row_before: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    $fell(cas_n_out[0]) |-> ras_n_out != '1)
    else $error("column strobe without row strobe");
  a_hit_match: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (req_valid_in && req_ready_out && clk_en_in) |=> hit_reg == $past(hit_one))
    else $error("bank hit not captured");
  a_col13_pin0: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (state_reg == dba_pkg::DBA_COL && thirteen && !req_reg.rom) |->
    ma_next[12:11] == 2'h0)
    else $error("column pin 0 used in 13 row mode");
  a_rom_noras: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (state_reg != dba_pkg::DBA_IDLE && req_reg.rom) |-> ras_n_next == '1)
    else $error("row strobe on rom access");
  c_hit_access: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
    $fell(cas_n_out[0]) && ras_n_out != '1);
  c_miss_access: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
    req_miss_out);
  c_ecc_access: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
    ecc_en_in && cas_n_out == 8'h00);
endmodule

/* File: verilog/dba_pkg.sv */
// Package: constants and carriers for the bank/address mux block
package dba_pkg;
  localparam int NUM_BANKS   = 8;
  localparam int MA_W        = 13;
  localparam int ROM_SEG_W   = 9;
  localparam int DATA_W      = 64;
  localparam int CHK_W       = 8;
  localparam int LANES       = 8;
  localparam int BOUND_W     = 10;  // Boundary in 4 Mbyte units, A[0:9]
  // Row-width setting codes
  localparam logic [1:0] ROW_9  = 2'h0;
  localparam logic [1:0] ROW_10 = 2'h1;
  localparam logic [1:0] ROW_11 = 2'h2;
  localparam logic [1:0] ROW_12 = 2'h3;
  // Reset values of the bank map
  localparam logic [7:0] BANK_EN_RST = 8'h00;
  localparam logic [1:0] ROW_RST     = 2'h0;
  // Cycle counts of the two address phases
  localparam logic [1:0] ROW_CYC = 2'h2;
  localparam logic [1:0] COL_CYC = 2'h2;

  typedef enum logic [1:0] {
    DBA_IDLE = 2'b00,
    DBA_ROW  = 2'b01,
    DBA_COL  = 2'b10
  } dba_state_t;

  typedef struct packed {
    logic [31:0] addr;    // Bit 31 is the big-endian A0
    logic [2:0]  tsize;
    logic        burst;
    logic        rom;
  } dba_req_t;

  typedef struct packed {
    logic [BOUND_W-1:0] start_mb;
    logic [BOUND_W-1:0] end_mb;
    logic [1:0]         row_code;
    logic               col13_11; // 13 row bits (only 11 column bits)
  } dba_bank_cfg_t;
endpackage

/* File: verilog/dba_lane_dec.sv */
// Byte-lane select decoder for the column strobes
`timescale 1ns/10ps
module dba_lane_dec (
  input  wire logic [2:0] addr_low_in,
  input  wire logic [2:0] tsize_in,
  input  wire logic       burst_in,
  input  wire logic       full_dw_in,
  output logic      [7:0] lanes_out
);
  logic [3:0]  nbytes;
  logic [15:0] mask_wide;

  // Size code 0 means eight bytes; burst is always a full double word
  assign nbytes    = (tsize_in == 3'h0) ? 4'h8 : {1'b0, tsize_in};
  assign mask_wide = {8'h00, 8'hff >> (4'h8 - nbytes)} << addr_low_in;
  // Lane 0 is the lowest address byte
  assign lanes_out = (full_dw_in || burst_in) ? 8'hff : mask_wide[7:0];
endmodule

/* File: testbench/dba_mem_model.sv */
// Behavioural memory banks on the far side of the strobe pins
`timescale 1ns/10ps
module dba_mem_model (
  input  wire logic        clk_in,
  input  wire logic [12:0] ma_in,
  input  wire logic [7:0]  ras_n_in,
  input  wire logic [7:0]  cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic [71:0] wr_in,
  output logic      [71:0] rd_out
);
  logic [71:0] mem [logic [33:0]];
  logic [71:0] last = 72'h0;
  logic [71:0] w;
  logic [12:0] row = 13'h0;
  logic [7:0]  ras_d = 8'hff;
  logic [33:0] key;
  logic        rd_en;
  // Word key: selected bank strobe, latched row, live column
  assign key   = {ras_n_in, row, ma_in};
  assign rd_en = (cas_n_in != 8'hff) && we_n_in;
  // Idle bus shows the inverse of the last value, never a stale copy
  always @* begin
    rd_out = ~last;
    if (rd_en && mem.exists(key)) rd_out = mem[key];
  end
  // Row taken on strobe fall, bytes written per column strobe
  always @(posedge clk_in) begin
    ras_d <= ras_n_in;
    if (ras_n_in != 8'hff && ras_d == 8'hff) row <= ma_in;
    if (rd_en) last <= rd_out;
    if (cas_n_in != 8'hff && !we_n_in) begin
      w = mem.exists(key) ? mem[key] : 72'h0;
      for (int i = 0; i < 8; i++)
        if (!cas_n_in[i]) begin
          w[63 - 8 * i -: 8] = wr_in[63 - 8 * i -: 8];
          w[64 + i] = wr_in[64 + i];
        end
      mem[key] = w;
    end
  end
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the bank select and address mux block
`timescale 1ns/10ps
module testbench;
  logic                         clk_sys_in = 1'b0;
  logic                         resetn_in = 1'b0;
  logic                         req_valid, req_write, ecc_en, rmw_en;
  dba_pkg::dba_req_t            req;
  logic [7:0]                   bank_en, wchk, rchk, chk_out, ras_n, cas_n;
  dba_pkg::dba_bank_cfg_t [7:0] cfg;
  logic [63:0]                  wdata, rdata, dq_out;
  logic [12:0]                  ma;
  logic                         ready, done, miss, we_n, d_oe_n, c_oe_n;
  logic [71:0]                  mem_rd, bm;
  int                           fail_count = 0;
  int                           cmp_count = 0;

  always #10 clk_sys_in = ~clk_sys_in;

  dba_bank_addr u_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .clk_en_in(1'b1), .req_valid_in(req_valid), .req_in(req),
    .req_write_in(req_write), .req_ready_out(ready), .req_done_out(done),
    .req_miss_out(miss), .bank_en_in(bank_en), .bank_cfg_in(cfg),
    .ecc_en_in(ecc_en), .rmw_par_en_in(rmw_en), .wdata_in(wdata),
    .wchk_in(wchk), .rdata_out(rdata), .rchk_out(rchk),
    .muxed_dram_addr_out(ma), .ras_n_out(ras_n), .cas_n_out(cas_n),
    .we_n_out(we_n), .data_upper_half_in(mem_rd[63:32]),
    .data_lower_half_in(mem_rd[31:0]), .data_upper_half_out(dq_out[63:32]),
    .data_lower_half_out(dq_out[31:0]), .data_oe_n_out(d_oe_n),
    .check_bit_lines_in(mem_rd[71:64]), .check_bit_lines_out(chk_out),
    .check_oe_n_out(c_oe_n));

  dba_mem_model u_mem (.clk_in(clk_sys_in), .ma_in(ma), .ras_n_in(ras_n),
    .cas_n_in(cas_n), .we_n_in(we_n), .wr_in({chk_out, dq_out}),
    .rd_out(mem_rd));

  task automatic give_verdict();
    $display("Mismatches %0d in %0d checks", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // Lowest enabled bank whose inclusive range holds A[0:9]
  function automatic int bank_of(logic [31:0] a);
    for (int i = 0; i < 8; i++)
      if (bank_en[i] && a[31:22] >= cfg[i].start_mb &&
          a[31:22] <= cfg[i].end_mb) return i;
    return -1;
  endfunction

  // Byte lanes from offset and size; check modes force a full word
  function automatic logic [7:0] lanes_of(logic [31:0] a, logic [2:0] sz,
                                          logic bst);
    int n;
    n = (sz == 3'h0) ? 8 : sz;
    if (bst || ecc_en || rmw_en) return 8'hff;
    for (int i = 0; i < 8; i++)
      lanes_of[i] = (i >= a[2:0]) && (i < a[2:0] + n);
  endfunction

  function automatic logic [71:0] mask_of(logic [7:0] l);
    for (int i = 0; i < 8; i++) begin
      mask_of[63 - 8 * i -: 8] = {8{l[i]}};
      mask_of[64 + i] = l[i];
    end
  endfunction

  // Mask and value of the pins in one phase; index 12 is the msb pin
  function automatic logic [25:0] exp_ma(logic [31:0] a, int b, bit col);
    logic [12:0] m, v;
    int          c;
    bit          t;
    c = cfg[b].row_code;
    t = cfg[b].col13_11;
    for (int j = 0; j < 13; j++) begin
      m[j] = col ? (j < 9 + c && !(t && j == 11)) : (j < 9 + c || t);
      v[j] = m[j] & a[col ? (j < 8 ? j + 3 : 12 + j + c)
                          : (j == 12 ? 26 : j + 11)];
    end
    return {m, v};
  endfunction

  task automatic access(input logic [31:0] a, input logic [2:0] sz,
                        input logic bst, input logic rom, input logic wr);
    int          b, dn;
    logic [25:0] er, ec;
    logic [12:0] m2, m4;
    logic [7:0]  r2, r4, c2, c4, el;
    logic        s4, w4, o4, q4, y4, y5;
    logic [71:0] wv, mk;
    wv = {8'($urandom), $urandom, $urandom};
    @(posedge clk_sys_in);
    // Map and mode written at the edge before have settled only now
    b = rom ? -1 : bank_of(a);
    el = lanes_of(a, sz, bst);
    req_valid <= 1'b1;
    req <= '{a, sz, bst, rom};
    req_write <= wr;
    {wchk, wdata} <= wv;
    @(posedge clk_sys_in);
    req_valid <= 1'b0;
    dn = 0;
    // Edges after the take: row at 2, column and answer at 3, idle at 5
    for (int n = 1; n <= 8; n++) begin
      @(posedge clk_sys_in);
      #1;
      if (done === 1'b1 && dn == 0) dn = n;
      if (n == 2) {m2, r2, c2} = {ma, ras_n, cas_n};
      if (n == 3) {m4, r4, c4, s4, w4, o4, q4, y4} =
                    {ma, ras_n, cas_n, miss, we_n, d_oe_n, c_oe_n, ready};
      if (n == 5) y5 = ready;
    end
    check(dn == 3, "done not at edge 3");
    check(y4 === 1'b0 && y5 === 1'b1, "ready outside idle");
    if (dn == 0) give_verdict();
    if (b < 0) begin
      check(r2 === 8'hff && r4 === 8'hff && c4 === 8'hff && s4 === 1'b1 &&
            {w4, o4, q4} === 3'h7, "strobe on a miss");
      if (rom)
        check(m2[8:0] === a[19:11] && m4[8:0] === a[19:11],
              "boot pins");
      return;
    end
    er = exp_ma(a, b, 1'b0);
    ec = exp_ma(a, b, 1'b1);
    check(r2 === ~(8'h01 << b) && r4 === r2 && c2 === 8'hff && s4 === 1'b0,
          "row strobe");
    check((m2 & er[25:13]) === er[12:0], "row pins");
    check((m4 & ec[25:13]) === ec[12:0], "column pins");
    check(c4 === ~el, "column strobes");
    check({w4, o4, q4} === {3{!wr}}, "write enable or drive");
    mk = mask_of(el);
    if (wr) bm = (bm & ~mk) | (wv & mk);
    else check({rchk, rdata} === bm, "read data");
  endtask

  initial begin
    logic [31:0] a;
    int          off;
    void'($urandom(32'h2a64dbb3));
    {req_valid, req_write, ecc_en, rmw_en} = 4'h0;
    req = '0;
    {wdata, wchk, bank_en, bm} = '0;
    cfg = '0;
    repeat (10) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      // Map is set before traffic; banks differ in organisation
      @(posedge clk_sys_in);
      ecc_en <= (r == 1);
      rmw_en <= (r == 2);
      bank_en <= 8'($urandom) | 8'h81;
      for (int i = 0; i < 8; i++)
        cfg[i] <= '{10'(i * 16 + r), 10'(i * 16 + 15), 2'(i), i == 7};
      for (int t = 0; t < 16; t++) begin
        off = (t % 4 == 0) ? r - 1 : (t % 4 == 1) ? r : (t % 4 == 2) ? 15
              : $urandom_range(0, 15);
        a = $urandom;
        a[31:22] = 10'($urandom_range(0, 8) * 16 + off);
        // Burst write seeds all lanes, then a partial write merges lanes
        access(a, 3'h0, 1'b1, 1'b0, 1'b1);
        access(a, 3'h0, 1'b0, 1'b0, 1'b0);
        access(a, 3'($urandom), t == 5, 1'b0, 1'b1);
        access(a, 3'h0, 1'b0, 1'b0, 1'b0);
        access(a, 3'h0, 1'b0, 1'b1, 1'b0);
      end
    end
    give_verdict();
  end
endmodule
